// *** logic/weie_pkg.sv ***
package weie_pkg;
  // APB byte addresses
  localparam logic [7:0] ADDR_GPIO_WAKE  = 8'h64;
  localparam logic [7:0] ADDR_INTERRUPT_ENDPOINT_CONTROL = 8'h68;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h80;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h84;
  localparam logic [7:0] ADDR_INTERVAL   = 8'h88;
  // Field layout
  localparam int NUM_PINS        = 11;
  localparam int NUM_MAC_EVT     = 9;
  localparam int POL_LSB         = 16;
  localparam int LINK_UP_BIT     = 31;
  localparam int ALWAYS_ON_BIT   = 31;
  localparam int MAC_EVT_LSB     = 11;
  localparam int LINK_PIN        = 7;
  localparam logic [31:0] WAKE_RW_MASK = 32'h87ff_07ff;
  localparam logic [31:0] CTL_RW_MASK  = 32'h800f_ffff;
  // Reset values
  localparam logic [31:0] CTL_RESET      = 32'h0000_0000;
  localparam logic [15:0] INTERVAL_RESET = 16'h0100;
  // Status bits
  localparam int ST_WAKE   = 0;
  localparam int ST_PACKET = 1;
  localparam int ST_LINK   = 2;
  localparam int ST_W      = 3;
endpackage : weie_pkg

// *** logic/weie_events.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Each of eleven pins has a wake enable; clear enable never wakes.
// - Polarity bit per pin: zero wakes on low, one wakes on high.
// - A pin used for another function never produces a wake event.
// - Link-up wake enable uses pin seven in either suspend state.
// - EEPROM load sets wake enables from the EEPROM image, zero without EEPROM; reset clears them.
// - USB or lite reset restores wake enables to last EEPROM image, zero without EEPROM.
// - Wake enable field is protected by the reset-protection mechanism.
// - Interrupt endpoint reports only events whose enable bit is set.
// - Always-on sends a packet every interval, else only after enabled events.
// - Bits 19..16 gate mac timeout, rx frame, tx stopped, rx stopped.
// - Bits 15..11 gate phy, tx error, underrun, overrun, rx drop.
// - Eleven pin interrupt enables gate pin events into packets.
module weie_events (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins and sources
  input  wire logic [10:0] pin_level,
  input  wire logic [10:0] pin_is_gpio,
  input  wire logic [8:0]  mac_event,
  input  wire logic        suspend_state_zero,
  input  wire logic        suspend_state_three,
  input  wire logic        usb_reset,
  input  wire logic        lite_reset,
  input  wire logic        reset_protect,
  input  wire logic        eeprom_present,
  input  wire logic [10:0] eeprom_wake_image,
  input  wire logic        eeprom_load,
  // Endpoint and wake outputs
  input  wire logic        ep_packet_taken,
  output logic             ep_packet_req,
  output logic [31:0]      ep_packet_status,
  output logic             wake_event,
  output logic             link_up_wake,
  output logic             irq
);

  typedef enum logic [1:0] {
    WEIE_IDLE  = 2'b00,
    WEIE_ARMED = 2'b01,
    WEIE_SEND  = 2'b11
  } weie_state_e;

  logic [10:0] pin_s1;
  logic [10:0] pin_s2;
  logic [10:0] gp_s1;
  logic [10:0] gp_s2;
  logic [10:0] pin_wake_enable;
  logic [10:0] pin_wake_polarity;
  logic        link_up_wake_enable;
  logic [31:0] ctl;
  logic [10:0] wake_image;
  logic [15:0] interval;
  logic [15:0] ivl_cnt;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic [31:0] pend;
  weie_state_e state;
  weie_state_e next_state;
  logic [10:0] pin_active;
  logic [10:0] pin_wake_hit;
  logic [31:0] evt_vec;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        link_hit;
  logic        any_wake;
  logic [2:0]  st_set;

  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite && pready;

  // Pins are asynchronous: two flops before use
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_s1 <= 11'h000;
      pin_s2 <= 11'h000;
      gp_s1  <= 11'h000;
      gp_s2  <= 11'h000;
    end
    else if (clk_en)
    begin
      pin_s1 <= pin_level;
      pin_s2 <= pin_s1;
      gp_s1  <= pin_is_gpio;
      gp_s2  <= gp_s1;
    end
  end

  // Per-pin qualification, bit n is pin n
  genvar g;
  generate
    for (g = 0; g < weie_pkg::NUM_PINS; g++)
    begin : g_pin
      assign pin_active[g]   = (pin_s2[g] == pin_wake_polarity[g]);
      assign pin_wake_hit[g] = pin_active[g] && pin_wake_enable[g] && gp_s2[g];
    end
  endgenerate

  assign link_hit = link_up_wake_enable && (suspend_state_zero || suspend_state_three)
                    && gp_s2[weie_pkg::LINK_PIN] && pin_active[weie_pkg::LINK_PIN];
  assign any_wake = |pin_wake_hit;

  // Event vector in the control register's layout
  assign evt_vec = {12'h000, mac_event, pin_active & gp_s2};

  // Wake enables: EEPROM image, bus resets, protection
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wake_image      <= 11'h000;
      pin_wake_enable <= 11'h000;
    end
    else if (clk_en)
    begin
      if (eeprom_load)
      begin
        wake_image      <= eeprom_present ? eeprom_wake_image : 11'h000;
        pin_wake_enable <= eeprom_present ? eeprom_wake_image : 11'h000;
      end
      else if ((usb_reset || lite_reset) && !reset_protect)
        pin_wake_enable <= eeprom_present ? wake_image : 11'h000;
      else if (wr && paddr == weie_pkg::ADDR_GPIO_WAKE && pstrb[0] && pstrb[1])
        pin_wake_enable <= pwdata[10:0];
    end
  end

  // Polarity and link-up enable
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_wake_polarity   <= 11'h000;
      link_up_wake_enable <= 1'b0;
    end
    else if (clk_en && wr && paddr == weie_pkg::ADDR_GPIO_WAKE)
    begin
      if (pstrb[2] && pstrb[3])
        pin_wake_polarity <= pwdata[26:16];
      if (pstrb[3])
        link_up_wake_enable <= pwdata[weie_pkg::LINK_UP_BIT];
    end
  end

  // Endpoint control and interval
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctl      <= weie_pkg::CTL_RESET;
      interval <= weie_pkg::INTERVAL_RESET;
      irq_mask <= 3'h0;
    end
    else if (clk_en && wr)
    begin
      if (paddr == weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL)
        ctl <= pwdata & weie_pkg::CTL_RW_MASK;
      if (paddr == weie_pkg::ADDR_INTERVAL)
        interval <= pwdata[15:0];
      if (paddr == weie_pkg::ADDR_IRQ_MASK)
        irq_mask <= pwdata[2:0];
    end
  end

  // Interval tick
  always_ff @(posedge clk)
  begin
    if (srst)
      ivl_cnt <= 16'h0000;
    else if (clk_en)
      ivl_cnt <= tick ? 16'h0000 : ivl_cnt + 16'h0001;
  end
  assign tick = (ivl_cnt >= interval);

  // Pending enabled events, set wins over clear on packet hand-off
  // Clearing an enable drops its pending bit one cycle later; a packet started in that cycle still reports it
  always_ff @(posedge clk)
  begin
    if (srst)
      pend <= 32'h0000_0000;
    else if (clk_en)
      pend <= ((ep_packet_taken ? 32'h0000_0000 : pend) | evt_vec)
              & ctl & 32'h000f_ffff;
  end

  // Packet scheduler
  always_comb
  begin
    next_state = state;
    case (state)
      WEIE_IDLE:  next_state = WEIE_ARMED;
      WEIE_ARMED:
        if (tick && (ctl[weie_pkg::ALWAYS_ON_BIT] || pend != 32'h0))
          next_state = WEIE_SEND;
      WEIE_SEND:
        if (ep_packet_taken)
          next_state = WEIE_ARMED;
      default:    next_state = WEIE_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state            <= WEIE_IDLE;
      ep_packet_req    <= 1'b0;
      ep_packet_status <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      state         <= next_state;
      ep_packet_req <= (next_state == WEIE_SEND);
      if (state == WEIE_ARMED && next_state == WEIE_SEND)
        ep_packet_status <= pend;
    end
  end

  // Wake outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wake_event   <= 1'b0;
      link_up_wake <= 1'b0;
    end
    else if (clk_en)
    begin
      wake_event   <= any_wake;
      link_up_wake <= link_hit;
    end
  end

  // Sticky status, read clears, new event wins
  assign st_set = {link_hit, state == WEIE_ARMED && next_state == WEIE_SEND, any_wake};
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_status <= 3'h0;
      irq        <= 1'b0;
    end
    else if (clk_en)
    begin
      // Clear only what the read returned; a bit set after the snapshot survives
      if (rd && paddr == weie_pkg::ADDR_IRQ_STATUS)
        irq_status <= (irq_status & ~prdata[2:0]) | st_set;
      else
        irq_status <= irq_status | st_set;
      irq        <= |(irq_status & irq_mask);
    end
  end

  // APB: one wait state, pready pulses in the access phase
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready)
      begin
        case (paddr)
          weie_pkg::ADDR_GPIO_WAKE:
            prdata <= {link_up_wake_enable, 4'h0, pin_wake_polarity, 5'h00, pin_wake_enable};
          weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL: prdata <= ctl;
          weie_pkg::ADDR_IRQ_STATUS: prdata <= {29'h0, irq_status};
          weie_pkg::ADDR_IRQ_MASK:   prdata <= {29'h0, irq_mask};
          weie_pkg::ADDR_INTERVAL:   prdata <= {16'h0000, interval};
          default:                   pslverr <= 1'b1;
        endcase
      end
    end
  end

  property p_no_foreign_wake;
    @(posedge clk) disable iff (srst)
      clk_en && (gp_s2 & pin_wake_enable) == 11'h000 |=> !wake_event;
  endproperty
  a_no_foreign_wake: assert property (p_no_foreign_wake) else $error("wake without enabled gpio");

  property p_polarity;
    @(posedge clk) disable iff (srst)
      clk_en && pin_wake_enable[0] && gp_s2[0] && pin_s2[0] == pin_wake_polarity[0]
      |=> wake_event;
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin0 active level missed");

  property p_link;
    @(posedge clk) disable iff (srst)
      clk_en && !suspend_state_zero && !suspend_state_three |=> !link_up_wake;
  endproperty
  a_link: assert property (p_link) else $error("link wake outside suspend");

  property p_restore;
    @(posedge clk) disable iff (srst)
      clk_en && lite_reset && !reset_protect && !eeprom_load && !eeprom_present
      |=> pin_wake_enable == 11'h000;
  endproperty
  a_restore: assert property (p_restore) else $error("lite reset restore wrong");

  property p_load;
    @(posedge clk) disable iff (srst)
      clk_en && eeprom_load && eeprom_present |=> pin_wake_enable == $past(eeprom_wake_image);
  endproperty
  a_load: assert property (p_load) else $error("eeprom load wrong");

  property p_gate;
    @(posedge clk) disable iff (srst)
      $rose(ep_packet_req) |-> (ep_packet_status & ~$past(ctl, 2)) == 32'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("disabled event reported");

  property p_quiet;
    @(posedge clk) disable iff (srst)
      state == WEIE_ARMED && !ctl[31] && pend == 32'h0 |=> !ep_packet_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("packet without event");

  property p_mac_gate;
    @(posedge clk) disable iff (srst)
      clk_en && mac_event[0] && ctl[11] && !ep_packet_taken |=> pend[11];
  endproperty
  a_mac_gate: assert property (p_mac_gate) else $error("rx drop event lost");

  c_wake: cover property (@(posedge clk) wake_event);
  c_link: cover property (@(posedge clk) link_up_wake);
  c_pkt:  cover property (@(posedge clk) ep_packet_req ##[1:20] ep_packet_taken);

endmodule : weie_events

// *** dv/weie_host_model.sv ***
`timescale 1ns/1ps
module weie_host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Endpoint
  input  wire logic        ep_packet_req,
  input  wire logic        slow,
  output logic             ep_packet_taken,
  output logic [7:0]       got_count
);
  logic [2:0] dly;
  // Slow polls keep the request waiting to prove it holds
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ep_packet_taken <= 1'b0;
      got_count       <= 8'h0;
      dly             <= 3'h0;
    end
    else
    begin
      ep_packet_taken <= 1'b0;
      if (ep_packet_req && !ep_packet_taken)
      begin
        dly <= dly + 3'h1;
        if (!slow || dly == 3'h5)
        begin
          ep_packet_taken <= 1'b1;
          got_count       <= got_count + 8'h1;
          dly             <= 3'h0;
        end
      end
    end
  end
endmodule : weie_host_model

// *** dv/wake_and_interrupt_endpoint_events_test.sv ***
`timescale 1ns/1ps
module wake_and_interrupt_endpoint_events_test;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, err, ia;
  logic [7:0]  paddr, got_count, c0;
  logic [31:0] pwdata, prdata, ep_packet_status, rd;
  logic [10:0] pin_level, pin_is_gpio, eeprom_wake_image;
  logic [8:0]  mac_event;
  logic        suspend_state_zero, suspend_state_three, usb_reset, lite_reset, reset_protect;
  logic        eeprom_present, eeprom_load, ep_packet_taken, ep_packet_req;
  logic        wake_event, link_up_wake, irq, slow;
  int          n_fail, n_compared;

  weie_events uut (
    .clk, .srst, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .pin_level, .pin_is_gpio,
    .mac_event, .suspend_state_zero, .suspend_state_three, .usb_reset,
    .lite_reset, .reset_protect, .eeprom_present, .eeprom_wake_image,
    .eeprom_load, .ep_packet_taken, .ep_packet_req, .ep_packet_status,
    .wake_event, .link_up_wake, .irq
  );
  weie_host_model host (
    .clk, .srst, .ep_packet_req, .slow, .ep_packet_taken, .got_count
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic summarize;
    $display("Counts: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
    begin
      n_fail++;
      $display("MISMATCH t=%0t apb wait ran out", $time);
      summarize;
    end
    @(posedge clk);
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic pkt(input logic exp);
    int k;
    for (k = 0; k < 40 && got_count === c0; k++)
      @(posedge clk);
    chk({31'h0, got_count !== c0}, {31'h0, exp});
  endtask : pkt

  task automatic t_regs;
    apb(1'b0, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL, 32'h0);
    chk(rd, weie_pkg::CTL_RESET);
    apb(1'b0, weie_pkg::ADDR_INTERVAL, 32'h0);
    chk(rd, {16'h0, weie_pkg::INTERVAL_RESET});
    apb(1'b0, 8'h00, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, weie_pkg::ADDR_GPIO_WAKE, 32'hffff_ffff);
    apb(1'b0, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    chk(rd, weie_pkg::WAKE_RW_MASK);
    apb(1'b1, weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL, 32'hffff_ffff);
    apb(1'b0, weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL, 32'h0);
    chk(rd, weie_pkg::CTL_RW_MASK);
    apb(1'b1, weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL, 32'h0);
    apb(1'b1, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    apb(1'b1, weie_pkg::ADDR_INTERVAL, 32'h4);
    $display("regs done");
  endtask : t_regs

  task automatic t_wake;
    apb(1'b1, weie_pkg::ADDR_GPIO_WAKE, 32'h0008_0008);
    cyc(5);
    chk({31'h0, wake_event}, 32'h0);
    pin_level[3] <= 1'b1;
    cyc(5);
    chk({31'h0, wake_event}, 32'h1);
    pin_is_gpio[3] <= 1'b0;
    cyc(5);
    chk({31'h0, wake_event}, 32'h0);
    pin_is_gpio[3] <= 1'b1;
    apb(1'b1, weie_pkg::ADDR_GPIO_WAKE, 32'h0000_0008);
    cyc(5);
    chk({31'h0, wake_event}, 32'h0);
    pin_level[3] <= 1'b0;
    cyc(5);
    chk({31'h0, wake_event}, 32'h1);
    apb(1'b1, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    cyc(5);
    chk({31'h0, wake_event}, 32'h0);
    pin_level <= 11'h7ff;
    $display("wake done");
  endtask : t_wake

  task automatic t_irq;
    apb(1'b1, weie_pkg::ADDR_IRQ_MASK, 32'h0);
    cyc(2);
    ia = irq;
    apb(1'b1, weie_pkg::ADDR_IRQ_MASK, 32'h7);
    cyc(2);
    chk({31'h0, ia ^ irq}, 32'h1);
    apb(1'b0, weie_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b0, weie_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    $display("irq done");
  endtask : t_irq

  task automatic t_restore;
    eeprom_present <= 1'b1;
    eeprom_wake_image <= 11'h5a5;
    eeprom_load <= 1'b1;
    @(posedge clk);
    eeprom_load <= 1'b0;
    apb(1'b0, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    chk(rd, 32'h5a5);
    apb(1'b1, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    reset_protect <= 1'b1;
    lite_reset <= 1'b1;
    @(posedge clk);
    lite_reset <= 1'b0;
    apb(1'b0, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    chk(rd, 32'h0);
    reset_protect <= 1'b0;
    lite_reset <= 1'b1;
    @(posedge clk);
    lite_reset <= 1'b0;
    apb(1'b0, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    chk(rd, 32'h5a5);
    eeprom_present <= 1'b0;
    usb_reset <= 1'b1;
    @(posedge clk);
    usb_reset <= 1'b0;
    apb(1'b0, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    chk(rd, 32'h0);
    $display("restore done");
  endtask : t_restore

  task automatic t_link;
    apb(1'b1, weie_pkg::ADDR_GPIO_WAKE, 32'h8080_0080);
    cyc(5);
    chk({31'h0, link_up_wake}, 32'h0);
    suspend_state_zero <= 1'b1;
    cyc(5);
    chk({31'h0, link_up_wake}, 32'h1);
    suspend_state_zero  <= 1'b0;
    suspend_state_three <= 1'b1;
    cyc(5);
    chk({31'h0, link_up_wake}, 32'h1);
    pin_is_gpio[7] <= 1'b0;
    cyc(5);
    chk({31'h0, link_up_wake}, 32'h0);
    pin_is_gpio[7] <= 1'b1;
    apb(1'b1, weie_pkg::ADDR_GPIO_WAKE, 32'h0080_0080);
    cyc(5);
    chk({31'h0, link_up_wake}, 32'h0);
    suspend_state_three <= 1'b0;
    apb(1'b1, weie_pkg::ADDR_GPIO_WAKE, 32'h0);
    $display("link done");
  endtask : t_link

  task automatic t_events;
    cyc(40);
    c0 = got_count;
    mac_event <= 9'h1ff;
    @(posedge clk);
    mac_event <= 9'h0;
    pkt(1'b0);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL, 32'h800 << i);
      c0 = got_count;
      mac_event <= 9'h1 << i;
      @(posedge clk);
      mac_event <= 9'h0;
      pkt(1'b1);
      chk(ep_packet_status, 32'h800 << i);
    end
    pin_level[3] <= 1'b0;
    apb(1'b1, weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL, 32'h8);
    c0 = got_count;
    pkt(1'b1);
    chk(ep_packet_status, 32'h0000_0008);
    apb(1'b1, weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL, 32'h0);
    pin_level <= 11'h7ff;
    $display("events done");
  endtask : t_events

  task automatic t_always;
    slow <= 1'b1;
    apb(1'b1, weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL, 32'h8000_0000);
    c0 = got_count;
    cyc(60);
    chk({31'h0, (got_count - c0) >= 8'h3}, 32'h1);
    chk(ep_packet_status, 32'h0);
    apb(1'b1, weie_pkg::ADDR_INTERRUPT_ENDPOINT_CONTROL, 32'h0);
    cyc(30);
    c0 = got_count;
    pkt(1'b0);
    $display("always done");
  endtask : t_always

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    {srst, slow} = 2'b10;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_level, mac_event, eeprom_wake_image} = '0;
    pin_is_gpio = 11'h7ff;
    {suspend_state_zero, suspend_state_three, usb_reset, lite_reset, reset_protect} = 5'h00;
    {eeprom_present, eeprom_load} = 2'b00;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_wake;
    t_irq;
    t_restore;
    t_link;
    t_events;
    t_always;
    summarize;
  end
endmodule : wake_and_interrupt_endpoint_events_test
